//--- src/cca_params.svh
// register offsets, field positions, reset values and counts of the array
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH
`define CCA_A_CTRL 8'h00
`define CCA_A_STS 8'h04
`define CCA_A_MSK 8'h08
`define CCA_A_CH_CFG 8'h40
`define CCA_A_CH_VAL 8'h80
`define CCA_O_TB_CFG 2'h0
`define CCA_O_TB_CNT 2'h1
`define CCA_F_STAG 2
`define CCA_F_SRC_HI 1
`define CCA_F_SRC_LO 0
`define CCA_F_PS_HI 4
`define CCA_F_PS_LO 2
`define CCA_F_TB 0
`define CCA_F_MODE_HI 3
`define CCA_F_MODE_LO 1
`define CCA_F_EDGE_RISE 4
`define CCA_F_EDGE_FALL 5
`define CCA_F_SEV 6
`define CCA_F_DBL 7
`define CCA_RST_TOP '0
`define CCA_RST_CH '0
`define CCA_STAG_LAST 3'h7
`define CCA_CNT_MAX 16'hffff
`endif

//--- src/cca_pkg.sv
// shared types of the capture/compare array
package cca_pkg;
    typedef enum logic [2:0] {
        CCA_OFF, CCA_CAP, CCA_RSV2, CCA_RSV3,
        CCA_CMP0, CCA_CMP1, CCA_CMP2, CCA_CMP3
    } cca_mode_t;
    typedef enum logic [1:0] {
        CCA_SRC_PRE, CCA_SRC_AUX, CCA_SRC_EXT, CCA_SRC_NONE
    } cca_src_t;
    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] val;
        logic pin;
        logic oe;
        logic fired;
        logic sev_done;
    } cca_ch_st_t;
    typedef struct packed {
        logic [2:0] ctrl;
        logic [2:0] phase;
        logic [1:0][4:0] tcfg;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] rld;
        logic [1:0][6:0] pre;
        logic [1:0] step;
        logic [1:0] ovf;
        logic [17:0] sts;
        logic [17:0] msk;
        logic [15:0] p1;
        logic [15:0] p2;
        logic [15:0] p3;
        logic [15:0] pf;
        logic [1:0] x1;
        logic [1:0] x2;
        logic [1:0] x3;
        logic [1:0] xf;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } cca_top_st_t;
endpackage

//--- src/cca_chan.sv
// one capture/compare channel: value register, mode logic and pin
`timescale 1ns/1ps
`include "cca_params.svh"
module cca_chan #(
    parameter bit DBL_OK = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_we,
    input wire logic val_we,
    input wire logic [15:0] wdata,
    input wire logic [15:0] tb0_val,
    input wire logic [15:0] tb1_val,
    input wire logic [1:0] tb_step,
    input wire logic [1:0] tb_ovf,
    input wire logic pin_rise,
    input wire logic pin_fall,
    input wire logic partner_match,
    output logic [7:0] cfg,
    output logic [15:0] val,
    output logic pin_out,
    output logic pin_oe,
    output logic match,
    output logic event_pls
);

cca_pkg::cca_ch_st_t st_r, st_nxt;
cca_pkg::cca_mode_t mode;
logic sel, is_cmp, lim, dbl, cap, cur_ovf;
logic [15:0] cur;

always_comb begin
    st_nxt = st_r;
    sel = st_r.cfg[`CCA_F_TB]; // see RL6
    mode = cca_pkg::cca_mode_t'(st_r.cfg[`CCA_F_MODE_HI:`CCA_F_MODE_LO]);
    cur = sel ? tb1_val : tb0_val;
    cur_ovf = tb_ovf[sel];
    is_cmp = st_r.cfg[`CCA_F_MODE_HI];
    lim = (mode == cca_pkg::CCA_CMP2) | (mode == cca_pkg::CCA_CMP3);
    dbl = DBL_OK & st_r.cfg[`CCA_F_DBL] & is_cmp;
    cap = (mode == cca_pkg::CCA_CAP)
        & ((pin_rise & st_r.cfg[`CCA_F_EDGE_RISE])
        | (pin_fall & st_r.cfg[`CCA_F_EDGE_FALL])); // see RL9
    // compare on each count step of the chosen base
    match = is_cmp & tb_step[sel] & (cur == st_r.val)
        & ~(lim & st_r.fired)
        & ~(st_r.sev_done & st_r.cfg[`CCA_F_SEV]); // see RL10 see RL17
    event_pls = cap | match; // see RL8 see RL11 see RL13
    st_nxt.oe = is_cmp; // see RL7
    if (cfg_we) begin
        st_nxt.cfg = wdata[7:0];
        st_nxt.fired = 1'b0;
        st_nxt.sev_done = 1'b0;
    end
    if (val_we) st_nxt.val = wdata;
    if (cur_ovf) st_nxt.fired = 1'b0;
    if (match & lim) st_nxt.fired = 1'b1; // see RL13 see RL14
    if (match & st_r.cfg[`CCA_F_SEV]) st_nxt.sev_done = 1'b1; // see RL16
    if ((mode == cca_pkg::CCA_CMP3) & cur_ovf) st_nxt.pin = 1'b0;
    if ((mode == cca_pkg::CCA_CMP3) & match) st_nxt.pin = 1'b1; // see RL14
    if ((mode == cca_pkg::CCA_CMP1) & match & ~dbl)
        st_nxt.pin = ~st_r.pin; // see RL12
    if (dbl & (match | partner_match)) st_nxt.pin = ~st_r.pin; // see RL15
    if (cap) st_nxt.val = cur; // see RL8
end

always_ff @(posedge clk) begin
    if (!nrst) st_r <= `CCA_RST_CH;
    else st_r <= st_nxt;
end

assign cfg = st_r.cfg;
assign val = st_r.val;
assign pin_out = st_r.pin;
assign pin_oe = st_r.oe;

default clocking @(posedge clk); endclocking
default disable iff (!nrst);

a_cap_latch: assert property (cap |=> st_r.val == $past(cur)) // see RL8
    else $error("capture did not latch the time base");
a_edge_sel: assert property (mode == cca_pkg::CCA_CAP // see RL9
    && !st_r.cfg[`CCA_F_EDGE_RISE] && pin_rise |-> !event_pls)
    else $error("capture taken on a deselected edge");
a_cmp0_pin: assert property (mode == cca_pkg::CCA_CMP0 && !dbl // see RL11
    |=> $stable(st_r.pin))
    else $error("interrupt-only mode moved the pin");
a_cmp1_tog: assert property (match && mode == cca_pkg::CCA_CMP1 // see RL12
    && !dbl |=> st_r.pin != $past(st_r.pin))
    else $error("toggle mode missed a toggle");
a_cmp2_once: assert property (lim && match && !cfg_we // see RL13
    ##1 !cur_ovf |-> !match)
    else $error("second match in one timer period");
a_cmp3_pulse: assert property (mode == cca_pkg::CCA_CMP3 // see RL14
    && cur_ovf && !match |=> !st_r.pin)
    else $error("overflow did not clear the pin");
a_dbl_tog: assert property (dbl && partner_match && !match // see RL15
    |=> st_r.pin != $past(st_r.pin))
    else $error("partner match did not toggle the pin");
a_single_ev: assert property (st_r.cfg[`CCA_F_SEV] && match // see RL16
    && !cfg_we |=> !match)
    else $error("single event channel fired again");

endmodule

//--- src/cca_top.sv
// top of the sixteen-channel capture/compare array with apb registers
//
// Notes on behaviour
// RL1: sixteen channels, one-cycle timing resolution.
// RL2: staggered mode steps every eighth cycle.
// RL3: two 16-bit time bases with reload.
// RL4: base clock prescaled or auxiliary overflow.
// RL5: time bases may count external inputs.
// RL6: each channel picks timer and function.
// RL7: one pin per channel, input or output.
// RL8: capture latches timer, raises request.
// RL9: capture edge rising, falling or both.
// RL10: compare channels match continuously against timer.
// RL11: mode 0 interrupts only, many per period.
// RL12: mode 1 toggles pin every match.
// RL13: mode 2 interrupts once per period.
// RL14: mode 3 sets on match, clears on overflow.
// RL15: double mode: two channels toggle one pin.
// RL16: single event limits channel to one event; the code limits compare matches only, captures are not limited.
// RL17: match checked each count step, registered.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "cca_params.svh"
module cca_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] cc_pin_in,
    output logic [15:0] cc_pin_out,
    output logic [15:0] cc_pin_oe,
    input wire logic aux_ovf,
    input wire logic [1:0] ext_cnt_in,
    output logic irq
);

// ----------------------------------------------------------------
// address decoding
// ----------------------------------------------------------------

function automatic logic ch_hit(
    input logic [7:0] a,
    input logic [7:0] base
);
    ch_hit = (a[7:6] == base[7:6]);
endfunction

// timer blocks at 0x10 and 0x20: cfg, count, reload
function automatic logic tb_hit(input logic [7:0] a);
    tb_hit = (a[7:6] == 2'h0) && (a[5] != a[4]) && (a[3:2] != 2'h3);
endfunction

function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01);
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------

cca_pkg::cca_top_st_t st_r, st_nxt;
logic [15:0][7:0] ch_cfg;
logic [15:0][15:0] ch_val;
logic [15:0] ch_match;
logic [15:0] ch_ev;
logic [15:0] we_cfg;
logic [15:0] we_val;
logic [3:0] idx;
logic acc_wr;
logic setup;
logic base;
logic tick;
logic [6:0] pmsk;
logic [17:0] clr;
logic [31:0] rd;
logic rd_ok;

// ----------------------------------------------------------------
// register write strobes and read mux
// ----------------------------------------------------------------

always_comb begin
    acc_wr = psel & penable & st_r.pready & pwrite;
    idx = paddr[5:2];
    we_cfg = '0;
    we_val = '0;
    if (acc_wr && ch_hit(paddr, `CCA_A_CH_CFG)) begin
        we_cfg[idx] = 1'b1;
    end
    if (acc_wr && ch_hit(paddr, `CCA_A_CH_VAL)) begin
        we_val[idx] = 1'b1;
    end
end

always_comb begin
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ch_hit(paddr, `CCA_A_CH_CFG)) begin
        rd = {24'h00_0000, ch_cfg[idx]};
    end else if (ch_hit(paddr, `CCA_A_CH_VAL)) begin
        rd = {16'h0000, ch_val[idx]};
    end else if (tb_hit(paddr)) begin
        case (paddr[3:2])
            `CCA_O_TB_CFG: rd = {27'h000_0000, st_r.tcfg[paddr[5]]};
            `CCA_O_TB_CNT: rd = {16'h0000, st_r.cnt[paddr[5]]};
            default: rd = {16'h0000, st_r.rld[paddr[5]]};
        endcase
    end else begin
        case (paddr)
            `CCA_A_CTRL: rd = {29'h0000_0000, st_r.ctrl};
            `CCA_A_STS: rd = {14'h0000, st_r.sts};
            `CCA_A_MSK: rd = {14'h0000, st_r.msk};
            default: rd_ok = 1'b0;
        endcase
    end
end

// ----------------------------------------------------------------
// bus answer, time bases, status
// ----------------------------------------------------------------

always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    pmsk = 7'h00;
    clr = '0;
    setup = psel & ~penable;
    // answer prepared in setup phase, zero wait states
    st_nxt.pready = setup;
    st_nxt.pslverr = setup & ~rd_ok;
    if (setup) begin
        st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    // three-stage pin and count input synchronisers
    st_nxt.p1 = cc_pin_in;
    st_nxt.p2 = st_r.p1;
    st_nxt.p3 = st_r.p2;
    st_nxt.x1 = ext_cnt_in;
    st_nxt.x2 = st_r.x1;
    st_nxt.x3 = st_r.x2;
    // filtered level moves only when stages two and three agree
    st_nxt.pf = (st_r.p2 & st_r.p3) | (st_r.pf & (st_r.p2 | st_r.p3));
    st_nxt.xf = (st_r.x2 & st_r.x3) | (st_r.xf & (st_r.x2 | st_r.x3));
    st_nxt.phase = st_r.phase + 3'h1;
    base = ~st_r.ctrl[`CCA_F_STAG]
        | (st_r.phase == `CCA_STAG_LAST); // see RL1 see RL2
    for (int t = 0; t < 2; t++) begin
        pmsk = ps_mask(st_r.tcfg[t][`CCA_F_PS_HI:`CCA_F_PS_LO]);
        case (cca_pkg::cca_src_t'(
            st_r.tcfg[t][`CCA_F_SRC_HI:`CCA_F_SRC_LO])) // see RL4
            cca_pkg::CCA_SRC_PRE: begin
                if (base) begin
                    st_nxt.pre[t] = st_r.pre[t] + 7'h01;
                end
                tick = base & ((st_r.pre[t] & pmsk) == pmsk);
            end
            cca_pkg::CCA_SRC_AUX: begin
                tick = aux_ovf;
            end
            cca_pkg::CCA_SRC_EXT: begin
                tick = st_r.x2[t] & st_r.x3[t] & ~st_r.xf[t]; // see RL5
            end
            default: begin
                tick = 1'b0;
            end
        endcase
        tick = tick & st_r.ctrl[t];
        st_nxt.step[t] = tick;
        st_nxt.ovf[t] = tick & (st_r.cnt[t] == `CCA_CNT_MAX);
        if (st_nxt.ovf[t]) begin
            st_nxt.cnt[t] = st_r.rld[t]; // see RL3
        end else if (tick) begin
            st_nxt.cnt[t] = st_r.cnt[t] + 16'h0001;
        end
    end
    if (acc_wr) begin
        case (paddr)
            `CCA_A_CTRL: st_nxt.ctrl = pwdata[2:0];
            `CCA_A_MSK: st_nxt.msk = pwdata[17:0];
            `CCA_A_STS: clr = pwdata[17:0];
            default: begin
                if (tb_hit(paddr)) begin
                    case (paddr[3:2])
                        `CCA_O_TB_CFG: begin
                            st_nxt.tcfg[paddr[5]] = pwdata[4:0];
                        end
                        `CCA_O_TB_CNT: begin
                            st_nxt.cnt[paddr[5]] = pwdata[15:0];
                        end
                        default: begin
                            st_nxt.rld[paddr[5]] = pwdata[15:0];
                        end
                    endcase
                end
            end
        endcase
    end
    // set wins over write-one-clear
    st_nxt.sts = (st_r.sts & ~clr) | {st_r.ovf, ch_ev}; // see RL8
    st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
end

always_ff @(posedge clk) begin
    if (!nrst) begin
        st_r <= `CCA_RST_TOP;
    end else begin
        st_r <= st_nxt;
    end
end

// ----------------------------------------------------------------
// channels
// ----------------------------------------------------------------

for (genvar n = 0; n < 16; n++) begin : g_ch
    cca_chan #(
        .DBL_OK(n < 8)
    ) u_ch (
        .clk(clk),
        .nrst(nrst),
        .cfg_we(we_cfg[n]),
        .val_we(we_val[n]),
        .wdata(pwdata[15:0]),
        .tb0_val(st_r.cnt[0]),
        .tb1_val(st_r.cnt[1]),
        .tb_step(st_r.step),
        .tb_ovf(st_r.ovf),
        .pin_rise(st_r.p2[n] & st_r.p3[n] & ~st_r.pf[n]),
        .pin_fall(~st_r.p2[n] & ~st_r.p3[n] & st_r.pf[n]),
        .partner_match(ch_match[(n + 8) % 16]),
        .cfg(ch_cfg[n]),
        .val(ch_val[n]),
        .pin_out(cc_pin_out[n]),
        .pin_oe(cc_pin_oe[n]),
        .match(ch_match[n]),
        .event_pls(ch_ev[n])
    );
end

assign prdata = st_r.prdata;
assign pready = st_r.pready;
assign pslverr = st_r.pslverr;
assign irq = st_r.irq;

// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------

default clocking @(posedge clk); endclocking
default disable iff (!nrst);

a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup phase");

a_tb_reload: assert property (st_r.ovf[0] && !$past(acc_wr) // see RL3
    |-> st_r.cnt[0] == $past(st_r.rld[0]))
    else $error("time base did not reload on overflow");

a_tb_count: assert property (st_r.step[1] && !st_r.ovf[1] // see RL3
    && !$past(acc_wr) |-> st_r.cnt[1] == 16'($past(st_r.cnt[1]) + 1))
    else $error("time base did not count by one");

a_stag_step: assert property (st_r.step[0] // see RL2
    && $past(st_r.ctrl[`CCA_F_STAG]) && $past(st_r.tcfg[0][1:0]) == 2'h0
    |-> $past(st_r.phase) == `CCA_STAG_LAST)
    else $error("staggered step off the eighth cycle");

a_aux_step: assert property (st_r.tcfg[0][1:0] == 2'h1 // see RL4
    && st_r.ctrl[0] && aux_ovf |=> st_r.step[0])
    else $error("auxiliary overflow did not step the base");

a_ext_step: assert property (st_r.tcfg[1][1:0] == 2'h2 // see RL5
    && st_r.ctrl[1] && st_r.x2[1] && st_r.x3[1] && !st_r.xf[1]
    |=> st_r.step[1])
    else $error("external count edge did not step the base");

a_sts_set: assert property (ch_ev[3] ##1 1'b1 // see RL8
    |-> st_r.sts[3] ##1 st_r.sts[3] || $past(acc_wr))
    else $error("channel request not kept");

a_irq_level: assert property (st_r.sts[0] && st_r.msk[0] // see RL8
    |-> irq)
    else $error("unmasked request without interrupt");

endmodule

//--- testbench/cca_pin_model.sv
// far-side model: channel pins, auxiliary overflow and external counts
`timescale 1ns/1ps
module cca_pin_model (
    input wire logic clk,
    input wire logic [15:0] cc_pin_out,
    input wire logic [15:0] cc_pin_oe,
    output logic [15:0] cc_pin_in,
    output logic aux_ovf,
    output logic [1:0] ext_cnt_in
);
    // ----------------------------------------
    // pin resolution and stimulus tasks
    // ----------------------------------------
    logic [15:0] drv_r;
    // a driven pin reads back the channel's own level
    assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drv_r);
    initial begin
        drv_r = 16'h0000;
        aux_ovf = 1'b0;
        ext_cnt_in = 2'b00;
    end
    task automatic set_pins(input logic [15:0] v);
        @(posedge clk);
        drv_r <= v;
    endtask
    // one-cycle pulses, gap plus one low cycles between them
    task automatic aux_pulse(input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            aux_ovf <= 1'b1;
            @(posedge clk);
            aux_ovf <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask
    // slow edges so the synchroniser sees each one
    task automatic ext_pulse(input int t, input int n);
        repeat (n) begin
            @(posedge clk);
            ext_cnt_in[t] <= 1'b1;
            repeat (4) @(posedge clk);
            ext_cnt_in[t] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

//--- testbench/capture_compare_array_16ch_tb.sv
// self-checking bench of the capture/compare array
`timescale 1ns/1ps
`include "cca_params.svh"
module capture_compare_array_16ch_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, aux_ovf, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rng, r1, r2;
    logic [15:0] cc_pin_in, cc_pin_out, cc_pin_oe, v;
    logic [1:0] ext_cnt_in;
    logic [32:0] q[$];
    int err_count, n_checks;
    cca_top dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cc_pin_in(cc_pin_in),
        .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .aux_ovf(aux_ovf),
        .ext_cnt_in(ext_cnt_in), .irq(irq));
    cca_pin_model pm_u (.clk(clk), .cc_pin_out(cc_pin_out),
        .cc_pin_oe(cc_pin_oe), .cc_pin_in(cc_pin_in), .aux_ovf(aux_ovf),
        .ext_cnt_in(ext_cnt_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [31:0] mk(input cca_pkg::cca_mode_t m,
            input logic [7:0] x);
        return {24'h0000_00, x | {4'h0, m, 1'b0}};
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input logic er = 1'b0);
        q.push_back({er, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // two aux steps through value x: exactly one match
    task automatic hit(input logic [15:0] x);
        wr(8'h14, {16'h0000, x - 16'h0001});
        pm_u.aux_pulse(2, 1);
        repeat (6) @(posedge clk);
    endtask
    task automatic pin(input int ch, input logic e);
        chk({32'h0000_0000, cc_pin_out[ch]}, {32'h0000_0000, e});
    endtask
    // read results leave the bus in order of request
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
            chk({pslverr, prdata}, q.size() ? q.pop_front() : 33'bx);
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        err_count = 0;
        n_checks = 0;
        rng = 32'h2b2d_e4cf;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(`CCA_A_CTRL, 32'h0000_0000);
        rd(`CCA_A_CH_CFG, 32'h0000_0000);
        rd(8'h0c, 32'h0000_0000, 1'b1);
        wr(8'h10, 32'h0000_0001);
        wr(`CCA_A_CTRL, 32'h0000_0001);
        wr(`CCA_A_MSK, 32'h0000_0001);
        for (int m = 0; m < 3; m += 2) begin
            rng = xs(rng);
            v = 16'(16'h1000 * (m + 1) + rng[11:0]);
            wr(8'(`CCA_A_CH_CFG + 4 * m), mk(m == 0 ? cca_pkg::CCA_CMP0 :
                cca_pkg::CCA_CMP2, 8'h00));
            wr(8'(`CCA_A_CH_VAL + 4 * m), {16'h0000, v});
            hit(v);
            rd(`CCA_A_STS, 32'(1 << m));
            chk({32'h0000_0000, irq}, {32'h0000_0000, m == 0});
            wr(`CCA_A_STS, 32'(1 << m));
            hit(v);
            rd(`CCA_A_STS, m == 0 ? 32'h0000_0001 : 32'h0000_0000);
            wr(`CCA_A_STS, 32'h0003_ffff);
        end
        repeat (3) @(posedge clk);
        chk({32'h0000_0000, irq}, 33'h0);
        wr(8'h44, mk(cca_pkg::CCA_CMP1, 8'h00));
        wr(8'h4c, mk(cca_pkg::CCA_CMP1, 8'h40));
        wr(8'h50, mk(cca_pkg::CCA_CMP3, 8'h00));
        wr(8'h84, 32'h0000_5100);
        wr(8'h8c, 32'h0000_5300);
        wr(8'h90, 32'h0000_5400);
        for (int i = 1; i < 5; i++) begin
            hit(16'(16'h5000 + 16'h0100 * i));
            pin(i, i != 2);
            chk({32'h0000_0000, cc_pin_oe[i]}, 33'h1);
        end
        wr(`CCA_A_STS, 32'h0003_ffff);
        hit(16'h5100);
        hit(16'h5300);
        hit(16'h5400);
        pin(1, 1'b0);
        pin(3, 1'b1);
        pin(4, 1'b1);
        rd(`CCA_A_STS, 32'h0000_0002);
        wr(`CCA_A_STS, 32'h0003_ffff);
        hit(16'h0000);
        pin(4, 1'b0);
        rd(`CCA_A_STS, 32'h0001_0000);
        wr(`CCA_A_CH_CFG, mk(cca_pkg::CCA_CMP1, 8'h80));
        wr(8'h60, mk(cca_pkg::CCA_CMP0, 8'h00));
        wr(8'ha0, 32'h0000_6800);
        wr(`CCA_A_CH_VAL, 32'h0000_5100);
        hit(16'h5100);
        pin(0, 1'b1);
        hit(16'h6800);
        pin(0, 1'b0);
        rng = xs(rng);
        r1 = {16'h0000, rng[15:0]};
        r2 = {16'h0000, rng[31:16]};
        wr(8'h24, r1);
        wr(8'h54, mk(cca_pkg::CCA_CAP, 8'h11));
        wr(8'h58, mk(cca_pkg::CCA_CAP, 8'h21));
        wr(8'h5c, mk(cca_pkg::CCA_CAP, 8'h31));
        wr(`CCA_A_STS, 32'h0003_ffff);
        pm_u.set_pins(16'h00e0);
        repeat (10) @(posedge clk);
        rd(8'h94, r1);
        rd(8'h98, 32'h0000_0000);
        rd(8'h9c, r1);
        rd(`CCA_A_STS, 32'h0000_00a0);
        wr(`CCA_A_STS, 32'h0003_ffff);
        wr(8'h24, r2);
        pm_u.set_pins(16'h0000);
        repeat (10) @(posedge clk);
        rd(8'h94, r1);
        rd(8'h98, r2);
        rd(8'h9c, r2);
        rd(`CCA_A_STS, 32'h0000_00c0);
        chk({32'h0000_0000, cc_pin_oe[5]}, 33'h0);
        wr(8'h20, 32'h0000_0002);
        wr(`CCA_A_CTRL, 32'h0000_0003);
        wr(8'h24, {17'h0_0000, rng[14:0]});
        pm_u.ext_pulse(1, int'(rng[18:16]) + 1);
        rd(8'h24, {17'h0_0000, rng[14:0]} + 32'(rng[18:16]) + 32'h1);
        // 64 run edges: eight staggered steps, then 64 plain steps
        wr(`CCA_A_CTRL, 32'h0000_0000);
        wr(8'h10, 32'h0000_0000);
        wr(8'h14, 32'h0000_0100);
        wr(`CCA_A_CTRL, 32'h0000_0005);
        repeat (61) @(posedge clk);
        wr(`CCA_A_CTRL, 32'h0000_0000);
        rd(8'h14, 32'h0000_0108);
        wr(`CCA_A_CTRL, 32'h0000_0001);
        repeat (61) @(posedge clk);
        wr(`CCA_A_CTRL, 32'h0000_0000);
        rd(8'h14, 32'h0000_0148);
        summarize();
    end
endmodule
